// ---- verilog/lief_defines.vh ----
// Constants for the link interrupt event flag block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef LIEF_DEFINES_VH
`define LIEF_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LIEF_OFS_EVT_SET 8'h80
`define LIEF_OFS_EVT_CLR 8'h84
`define LIEF_OFS_EVT_MASK_SET 8'h88
`define LIEF_OFS_EVT_MASK_CLR 8'h8C
`define LIEF_OFS_EVT_RAW 8'h90
`define LIEF_OFS_CTRL 8'h94
`define LIEF_OFS_PHY_DATA 8'h98
`define LIEF_OFS_TIMER 8'h9C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LIEF_BIT_SOFT 29
`define LIEF_BIT_LATE_ACK 27
`define LIEF_BIT_PHY_BYTE 26
`define LIEF_BIT_OVERRUN 25
`define LIEF_BIT_FATAL 24
`define LIEF_BIT_MISMATCH 23
`define LIEF_BIT_ISO_RX 7
`define LIEF_BIT_ISO_TX 6
`define LIEF_RSVD_HI_MSB 31
`define LIEF_RSVD_HI_LSB 30
`define LIEF_BIT_RSVD_MID 28
`define LIEF_CTRL_LATE_ACK_EN 29
`define LIEF_CTRL_ROOT_EN 21
`define LIEF_PHY_LSB 16
`define LIEF_PHY_MSB 23
`define LIEF_SEC_LSB 25
`define LIEF_SEC_MSB 31
`define LIEF_TICK_LSB 12
`define LIEF_TICK_MSB 24

// ----------------------------------------
// Masks and reset values
// ----------------------------------------
// Latched flags: 29, 27..23
`define LIEF_LATCH_MASK 32'h2F80_0000
`define LIEF_ZERO32 32'h0000_0000
`define LIEF_RESP_OKAY 2'h0
`define LIEF_RESP_SLVERR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define LIEF_OVERRUN_NS 125000
`define LIEF_CLK_NS 50

`endif

// ---- verilog/lief_event_flags.v ----
// Interrupt event flag register of a serial-bus link layer, AXI4-Lite slave.
// Assumes event sources are synchronous to aclk; cycle markers are one-cycle
// pulses; software reaches registers over AXI4-Lite with one access at a time.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "lief_defines.vh"

module lief_event_flags #(
  parameter OVERRUN_CYCLES = `LIEF_OVERRUN_NS / `LIEF_CLK_NS,
  parameter CTX_COUNT = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_fifo_pending,
  input wire phys_resp_busy,
  input wire ack_tardy_sent,
  input wire phy_reg_byte_arrived,
  input wire [7:0] phy_reg_byte,
  input wire cycle_start_tx,
  input wire subaction_gap_end,
  input wire cycle_start_rx,
  input wire [6:0] rx_timer_second_field,
  input wire [12:0] rx_timer_tick_field,
  input wire [CTX_COUNT-1:0] ctx_dead,
  input wire [CTX_COUNT-1:0] ctx_event,
  input wire iso_rx_pending,
  input wire iso_tx_pending,
  output reg irq,
  output reg root_timing_enable,
  output reg late_ack_report_enable,
  output reg [CTX_COUNT-1:0] ctx_event_flag
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [31:0] flags_r;
  reg [31:0] mask_r;
  reg [7:0] phy_byte_r;
  reg [6:0] timer_second_field_r;
  reg [12:0] timer_tick_field_r;
  reg [CTX_COUNT-1:0] fatal_ctx_r;
  reg [31:0] src_prev_r;
  reg overrun_run_r;
  reg [31:0] overrun_cnt_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg aw_held_r;
  reg w_held_r;

  // ----------------------------------------
  // Byte-lane write data
  // ----------------------------------------
  // Strobed-off bytes become zeros, which neither set nor clear a flag
  wire [31:0] strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] wbits = wdata_r & strb_mask;
  wire do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  wire wr_set = do_write && (awaddr_r == `LIEF_OFS_EVT_SET);
  wire wr_clr = do_write && (awaddr_r == `LIEF_OFS_EVT_CLR);

  // ----------------------------------------
  // Channel handshakes
  // ----------------------------------------
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire b_take = s_axi_bvalid && s_axi_bready;
  wire r_take = s_axi_rvalid && s_axi_rready;

  // ----------------------------------------
  // Hardware event sources
  // ----------------------------------------
  wire late_ack_cond = rx_fifo_pending | phys_resp_busy | ack_tardy_sent;
  wire overrun_hit = overrun_run_r && root_timing_enable &&
    (overrun_cnt_r >= OVERRUN_CYCLES) && !subaction_gap_end;
  wire mismatch = cycle_start_rx && ((rx_timer_second_field != timer_second_field_r) ||
    (rx_timer_tick_field != timer_tick_field_r));
  reg [31:0] src_now;
  always @* begin
    src_now = `LIEF_ZERO32;
    src_now[`LIEF_BIT_LATE_ACK] = late_ack_report_enable & late_ack_cond;
    src_now[`LIEF_BIT_PHY_BYTE] = phy_reg_byte_arrived;
    src_now[`LIEF_BIT_OVERRUN] = overrun_hit;
    src_now[`LIEF_BIT_FATAL] = |ctx_dead;
    src_now[`LIEF_BIT_MISMATCH] = mismatch;
  end
  // Asserting edges only; a level that stays high does not re-set a cleared flag
  wire [31:0] src_edge = src_now & ~src_prev_r;

  // ----------------------------------------
  // Flag update: set wins over clear so no event is lost
  // ----------------------------------------
  reg [31:0] flags_nxt;
  always @* begin
    flags_nxt = flags_r;
    if (wr_clr) begin
      flags_nxt = flags_nxt & ~(wbits & `LIEF_LATCH_MASK);
    end
    flags_nxt = flags_nxt | (src_edge & `LIEF_LATCH_MASK);
    if (wr_set) begin
      flags_nxt = flags_nxt | (wbits & `LIEF_LATCH_MASK);
    end
    flags_nxt[`LIEF_RSVD_HI_MSB:`LIEF_RSVD_HI_LSB] = 2'h0;
    flags_nxt[`LIEF_BIT_RSVD_MID] = 1'b0;
    flags_nxt[`LIEF_BIT_ISO_RX] = iso_rx_pending;
    flags_nxt[`LIEF_BIT_ISO_TX] = iso_tx_pending;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  reg [31:0] rd_val;
  reg rd_ok;
  // Unknown offsets read zero and answer with an error
  always @* begin
    rd_ok = 1'b1;
    if (s_axi_araddr == `LIEF_OFS_EVT_SET || s_axi_araddr == `LIEF_OFS_EVT_CLR) begin
      rd_val = flags_r & mask_r;
    end else if (s_axi_araddr == `LIEF_OFS_EVT_MASK_SET || s_axi_araddr == `LIEF_OFS_EVT_MASK_CLR) begin
      rd_val = mask_r;
    end else if (s_axi_araddr == `LIEF_OFS_EVT_RAW) begin
      rd_val = flags_r;
    end else if (s_axi_araddr == `LIEF_OFS_CTRL) begin
      rd_val = `LIEF_ZERO32;
      rd_val[`LIEF_CTRL_LATE_ACK_EN] = late_ack_report_enable;
      rd_val[`LIEF_CTRL_ROOT_EN] = root_timing_enable;
    end else if (s_axi_araddr == `LIEF_OFS_PHY_DATA) begin
      rd_val = `LIEF_ZERO32;
      rd_val[`LIEF_PHY_MSB:`LIEF_PHY_LSB] = phy_byte_r;
    end else if (s_axi_araddr == `LIEF_OFS_TIMER) begin
      rd_val = `LIEF_ZERO32;
      rd_val[`LIEF_SEC_MSB:`LIEF_SEC_LSB] = timer_second_field_r;
      rd_val[`LIEF_TICK_MSB:`LIEF_TICK_LSB] = timer_tick_field_r;
    end else begin
      rd_val = `LIEF_ZERO32;
      rd_ok = 1'b0;
    end
  end

  // Raw flags and PHY byte are read-only, so writes there are refused
  wire wr_known = (awaddr_r == `LIEF_OFS_EVT_SET) || (awaddr_r == `LIEF_OFS_EVT_CLR) ||
    (awaddr_r == `LIEF_OFS_EVT_MASK_SET) || (awaddr_r == `LIEF_OFS_EVT_MASK_CLR) ||
    (awaddr_r == `LIEF_OFS_CTRL) || (awaddr_r == `LIEF_OFS_TIMER);

  // ----------------------------------------
  // Write address channel
  // ----------------------------------------
  // Ready is a one-cycle pulse, so a valid that is still held is never taken twice
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else begin
      s_axi_awready <= !aw_held_r && s_axi_awvalid && !s_axi_awready;
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Write data channel
  // ----------------------------------------
  // Data may come before, with or after its address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held_r <= 1'b0;
      wdata_r <= `LIEF_ZERO32;
      wstrb_r <= 4'h0;
    end else begin
      s_axi_wready <= !w_held_r && s_axi_wvalid && !s_axi_wready;
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Write response channel
  // ----------------------------------------
  // The response follows both halves; a refused write changes nothing
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LIEF_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `LIEF_RESP_OKAY : `LIEF_RESP_SLVERR;
    end else if (b_take) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read channels
  // ----------------------------------------
  // A new address waits while read data is still offered
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `LIEF_RESP_OKAY;
      s_axi_rdata <= `LIEF_ZERO32;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `LIEF_RESP_OKAY : `LIEF_RESP_SLVERR;
      end else if (r_take) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Mask, cycle timer and late-ack enable
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= `LIEF_ZERO32;
      timer_second_field_r <= 7'h00;
      timer_tick_field_r <= 13'h0000;
      late_ack_report_enable <= 1'b0;
    end else if (do_write) begin
      if (awaddr_r == `LIEF_OFS_EVT_MASK_SET) begin
        mask_r <= mask_r | wbits;
      end else if (awaddr_r == `LIEF_OFS_EVT_MASK_CLR) begin
        mask_r <= mask_r & ~wbits;
      end else if (awaddr_r == `LIEF_OFS_TIMER) begin
        timer_second_field_r <= wbits[`LIEF_SEC_MSB:`LIEF_SEC_LSB];
        timer_tick_field_r <= wbits[`LIEF_TICK_MSB:`LIEF_TICK_LSB];
      end else if (awaddr_r == `LIEF_OFS_CTRL) begin
        late_ack_report_enable <= wbits[`LIEF_CTRL_LATE_ACK_EN];
      end
    end
  end

  // ----------------------------------------
  // Root timing enable
  // ----------------------------------------
  // The hardware clear on overrun beats a software write in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      root_timing_enable <= 1'b0;
    end else if (overrun_hit) begin
      root_timing_enable <= 1'b0;
    end else if (do_write && awaddr_r == `LIEF_OFS_CTRL) begin
      root_timing_enable <= wbits[`LIEF_CTRL_ROOT_EN];
    end
  end

  // ----------------------------------------
  // Event flags and PHY byte capture
  // ----------------------------------------
  // Edge history is kept per bit, so a source held high fires only once
  always @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= `LIEF_ZERO32;
      src_prev_r <= `LIEF_ZERO32;
      phy_byte_r <= 8'h00;
    end else begin
      flags_r <= flags_nxt;
      src_prev_r <= src_now;
      if (phy_reg_byte_arrived) begin
        phy_byte_r <= phy_reg_byte;
      end
    end
  end

  // ----------------------------------------
  // Overrun timer
  // ----------------------------------------
  // Runs from cycle start send to subaction gap end; stops if the enable drops
  always @(posedge aclk) begin
    if (!aresetn) begin
      overrun_run_r <= 1'b0;
      overrun_cnt_r <= `LIEF_ZERO32;
    end else if (cycle_start_tx && root_timing_enable) begin
      overrun_run_r <= 1'b1;
      overrun_cnt_r <= `LIEF_ZERO32;
    end else if (subaction_gap_end || overrun_hit || !root_timing_enable) begin
      overrun_run_r <= 1'b0;
    end else if (overrun_run_r) begin
      overrun_cnt_r <= overrun_cnt_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Context blame and interrupt gating
  // ----------------------------------------
  // Contexts that went dead stay blamed until the fatal flag clears
  always @(posedge aclk) begin
    if (!aresetn) begin
      fatal_ctx_r <= {CTX_COUNT{1'b0}};
      ctx_event_flag <= {CTX_COUNT{1'b0}};
    end else begin
      if (!flags_nxt[`LIEF_BIT_FATAL]) begin
        fatal_ctx_r <= {CTX_COUNT{1'b0}};
      end else begin
        fatal_ctx_r <= fatal_ctx_r | ctx_dead;
      end
      ctx_event_flag <= ctx_event & ~(fatal_ctx_r | ctx_dead);
    end
  end

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  // Built from the next flag value so irq does not trail the flags by a cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_nxt & mask_r);
    end
  end

endmodule // lief_event_flags

// ---- verif/lief_props_properties.sv ----
// Checker for the event flag block: bus holds, reserved bits, irq, overrun.
// Assumes bind to lief_event_flags; one clock domain.
`timescale 1ns/1ns
module lief_props #(
  parameter OVERRUN_CYCLES = 2500,
  parameter CTX_COUNT = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire cycle_start_tx,
  input wire subaction_gap_end,
  input wire [CTX_COUNT-1:0] ctx_event,
  input wire [CTX_COUNT-1:0] ctx_event_flag,
  input wire irq,
  input wire root_timing_enable
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  reg [7:0] ra_r;
  reg [31:0] oc_r;
  wire evt_rd = s_axi_rvalid && (ra_r == 8'h80 || ra_r == 8'h84);
  always @(posedge aclk) begin
    if (!aresetn) ra_r <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
  end
  // Counts a cycle in flight; stops once the enable drops, so a later re-enable is clean
  always @(posedge aclk) begin
    if (!aresetn || subaction_gap_end || !root_timing_enable) oc_r <= 32'h0000_0000;
    else if (cycle_start_tx) oc_r <= 32'h0000_0001;
    else if (oc_r != 0 && oc_r < OVERRUN_CYCLES + 4) oc_r <= oc_r + 1;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_top_resv: assert property (evt_rd |-> s_axi_rdata[31:30] == 2'h0)
    else $error("top reserved bits read nonzero");
  chk_bit28_resv: assert property (evt_rd |-> !s_axi_rdata[28])
    else $error("bit 28 read nonzero");
  chk_irq_read: assert property ($rose(s_axi_rvalid) && evt_rd && s_axi_rdata[29:23] != 0 |-> ##[0:1] irq)
    else $error("irq low with masked flag set");
  chk_ctx_gate: assert property ((ctx_event_flag & ~$past(ctx_event)) == 0)
    else $error("context flag without request");
  chk_overrun_clr: assert property (oc_r == OVERRUN_CYCLES + 2 |-> !root_timing_enable)
    else $error("root timing enable kept after overrun");
  chk_rvalid_after: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  cover property (evt_rd && s_axi_rdata[29]);
  cover property ($fell(root_timing_enable));
  cover property ($rose(irq));
endmodule // lief_props

// ---- verif/testbench.sv ----
// Self-checking bench for lief_event_flags over AXI4-Lite.
// Assumes the design and lief_props are compiled first.
`timescale 1ns/1ns
module testbench;
  reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  reg s_axi_rready = 0, rx_fifo_pending = 0, phys_resp_busy = 0, ack_tardy_sent = 0, phy_reg_byte_arrived = 0;
  reg cycle_start_tx = 0, subaction_gap_end = 0, cycle_start_rx = 0, iso_rx_pending = 0, iso_tx_pending = 0;
  reg [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, phy_reg_byte = '0;
  reg [31:0] s_axi_wdata = '0;
  reg [3:0] s_axi_wstrb = '0, ctx_dead = '0, ctx_event = '0;
  reg [6:0] rx_timer_second_field = '0;
  reg [12:0] rx_timer_tick_field = '0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire root_timing_enable, late_ack_report_enable;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] ctx_event_flag;
  int errors = 0, total_checks = 0;
  logic [31:0] rv;
  logic [1:0] rr;
  lief_event_flags #(.OVERRUN_CYCLES(20)) lief_event_flags_i (.*);
  initial forever #25 aclk = ~aclk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    rr = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_soft;
    wr(8'h88, 32'hffff_ffff);
    chk("bresp okay", rr, 2'h0);
    wr(8'h80, 32'hffff_ffff);
    rd(8'h80);
    chk("set all", rv, 32'h2f80_0000);
    chk("rresp okay", rr, 2'h0);
    chk("irq", irq, 1);
    wr(8'h84, 32'h0000_0000);
    rd(8'h84);
    chk("clear zero", rv, 32'h2f80_0000);
    wr(8'h84, 32'hffff_ffff);
    iso_rx_pending <= 1;
    rd(8'h80);
    chk("cleared", rv, 32'h0000_0080);
    wr(8'h84, 32'h0000_00c0);
    rd(8'h80);
    chk("iso bits", rv, 32'h0000_0080);
    iso_rx_pending <= 0;
    $display("t_soft done");
  endtask
  task automatic t_mask;
    wr(8'h8c, 32'h2000_0000);
    wr(8'h80, 32'h2000_0000);
    rd(8'h80);
    chk("masked", rv, 32'h0000_0000);
    chk("irq off", irq, 0);
    wr(8'h90, 32'hffff_ffff);
    chk("read-only write", rr, 2'h2);
    rd(8'h90);
    chk("raw", rv, 32'h2000_0000);
    wr(8'h88, 32'h2000_0000);
    wr(8'h84, 32'h2000_0000);
    rd(8'h40);
    chk("unmapped", rr, 2'h2);
    chk("unmapped data", rv, 32'h0000_0000);
    wr(8'h80, 32'h2f80_0000, 4'h4);
    rd(8'h90);
    chk("strobe", rv, 32'h0080_0000);
    wr(8'h84, 32'h0080_0000);
    $display("t_mask done");
  endtask
  task automatic t_phy;
    phy_reg_byte <= 8'ha5;
    phy_reg_byte_arrived <= 1;
    tick(3);
    rd(8'h80);
    chk("phy flag", rv, 32'h0400_0000);
    wr(8'h84, 32'h0400_0000);
    rd(8'h80);
    chk("level no reset", rv, 32'h0000_0000);
    rd(8'h98);
    chk("phy byte", rv, 32'h00a5_0000);
    phy_reg_byte_arrived <= 0;
    $display("t_phy done");
  endtask
  task automatic t_late;
    rx_fifo_pending <= 1;
    tick(3);
    rd(8'h80);
    chk("late off", rv, 32'h0000_0000);
    rx_fifo_pending <= 0;
    wr(8'h94, 32'h2000_0000);
    chk("late en", late_ack_report_enable, 1);
    for (int i = 0; i < 3; i++) begin
      {ack_tardy_sent, phys_resp_busy, rx_fifo_pending} <= 3'h1 << i;
      tick(3);
      rd(8'h80);
      chk("late cause", rv, 32'h0800_0000);
      {ack_tardy_sent, phys_resp_busy, rx_fifo_pending} <= 3'h0;
      wr(8'h84, 32'h0800_0000);
    end
    wr(8'h94, 32'h0000_0000);
    $display("t_late done");
  endtask
  task automatic t_cyc;
    wr(8'h9c, {7'h12, 13'h0abc, 12'h000});
    for (int k = 0; k < 2; k++) begin
      rx_timer_second_field <= 7'h12 + k[6:0];
      rx_timer_tick_field <= 13'h0abc;
      cycle_start_rx <= 1;
      tick(1);
      cycle_start_rx <= 0;
      tick(2);
      rd(8'h80);
      chk("mismatch", rv, k ? 32'h0080_0000 : 32'h0000_0000);
    end
    wr(8'h84, 32'h0080_0000);
    $display("t_cyc done");
  endtask
  task automatic t_ovr;
    wr(8'h94, 32'h0020_0000);
    for (int k = 0; k < 2; k++) begin
      cycle_start_tx <= 1;
      tick(1);
      cycle_start_tx <= 0;
      tick(5);
      subaction_gap_end <= !k;
      tick(1);
      subaction_gap_end <= 0;
      tick(30);
      rd(8'h80);
      chk("overrun", rv, k ? 32'h0200_0000 : 32'h0000_0000);
      chk("root en", root_timing_enable, !k);
    end
    wr(8'h84, 32'h0200_0000);
    $display("t_ovr done");
  endtask
  task automatic t_fatal;
    ctx_dead <= 4'h1;
    tick(3);
    rd(8'h80);
    chk("fatal", rv, 32'h0100_0000);
    ctx_event <= 4'h3;
    tick(3);
    chk("blocked", ctx_event_flag, 4'h2);
    ctx_event <= 4'h0;
    ctx_dead <= 4'h0;
    wr(8'h84, 32'h0100_0000);
    ctx_event <= 4'h1;
    tick(3);
    chk("unblocked", ctx_event_flag, 4'h1);
    ctx_event <= 4'h0;
    $display("t_fatal done");
  endtask
  task automatic t_rst;
    wr(8'h80, 32'h2000_0000);
    wr(8'h94, 32'h0020_0000);
    chk("irq before reset", irq, 1);
    aresetn <= 0;
    tick(2);
    aresetn <= 1;
    chk("irq after reset", irq, 0);
    chk("root after reset", root_timing_enable, 0);
    rd(8'h90);
    chk("flags after reset", rv, 32'h0000_0000);
    rd(8'h88);
    chk("mask after reset", rv, 32'h0000_0000);
    $display("t_rst done");
  endtask
  // ----------------------------------------
  // Run and verdict
  // ----------------------------------------
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    errors++;
    print_verdict;
  end
  initial begin
    tick(20);
    aresetn <= 1;
    t_soft;
    t_mask;
    t_phy;
    t_late;
    t_cyc;
    t_ovr;
    t_fatal;
    t_rst;
    print_verdict;
  end
endmodule // testbench
bind lief_event_flags lief_props #(.OVERRUN_CYCLES(OVERRUN_CYCLES), .CTX_COUNT(CTX_COUNT)) lief_props_i (.*);
